// >>> bcmcr_mode_cfg.sv
`timescale 1ns/1ps
module bcmcr_mode_cfg
	import bcmcr_pkg::*;
#(
	parameter int UNIT_CYCLES = BCMCR_UNIT_CYCLES
)
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [4:0] host_addr,
	input wire logic [15:0] host_wdata,
	input wire logic host_wr,
	input wire logic host_rd,
	output logic [15:0] host_rdata_r,
	input wire logic host_frame_start,
	input wire logic cfg3_enhanced,
	input wire logic [15:0] frame_time,
	input wire logic retry_enable,
	input wire bcmcr_msg_t msg,
	input wire logic frame_done,
	input wire logic frame_trigger_input,
	output logic frame_start_r,
	output logic bc_halt_r,
	output logic bc_active_r,
	output logic bc_mode_r,
	output logic enhanced_r,
	output logic memory_area_r
);

	logic [15:0] cfg_r;
	logic [15:0] cfg_nxt;
	logic [15:0] rdata_nxt;
	bcmcr_state_t state_r;
	bcmcr_state_t state_nxt;
	logic frame_abort_r;
	logic frame_abort_nxt;
	logic frame_start_nxt;
	logic bc_halt_nxt;
	logic trig_rise;
	logic timer_expired;
	logic bc_mode;
	logic enh;
	logic abort_me;
	logic en_frame_err;
	logic en_msg_stat;
	logic en_frame_stat;
	logic auto_frame_repeat;
	logic internal_trigger_enable;
	logic ext_en;
	logic fail_err;
	logic fail_stat;
	logic msg_stop;
	logic start_req;

	function automatic logic cfg1_hit(input logic [4:0] addr);
		cfg1_hit = (addr == BCMCR_CFG1_ADDR);
	endfunction

	// A failed outcome counts only when no successful retry rescued it.
	function automatic logic failed(input logic cond, input logic ok);
		failed = cond & ~ok;
	endfunction

	bcmcr_trig_sync u_trig
	(
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.pin_in(frame_trigger_input),
		.rise_r(trig_rise)
	);

	bcmcr_frame_timer #(
		.UNIT_CYCLES(UNIT_CYCLES)
	) u_timer
	(
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.start(frame_start_r),
		.units(frame_time),
		.expired_r(timer_expired)
	);

	always_comb
	begin
		cfg_nxt = cfg_r;
		rdata_nxt = host_rdata_r;
		if (host_wr && cfg1_hit(host_addr))
		begin
			cfg_nxt = host_wdata;
		end
		if (host_rd)
		begin
			// Other offsets belong to neighbouring registers; read zero here.
			rdata_nxt = cfg1_hit(host_addr) ? cfg_r : 16'h0000;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cfg_r <= BCMCR_CFG1_RESET;
			host_rdata_r <= 16'h0000;
		end
		else
		begin
			cfg_r <= cfg_nxt;
			host_rdata_r <= rdata_nxt;
		end
	end

	always_comb
	begin
		bc_mode = ~cfg_r[BCMCR_OP_MODE_BIT];
		enh = bc_mode & cfg3_enhanced;
		abort_me = bc_mode & cfg_r[BCMCR_ABORT_MSG_ERR_BIT];
		// Enhanced-only controls are gated so legacy mode ignores them.
		en_frame_err = enh & cfg_r[BCMCR_ABORT_FRM_ERR_BIT];
		en_msg_stat = enh & cfg_r[BCMCR_ABORT_MSG_STAT_BIT];
		en_frame_stat = enh & cfg_r[BCMCR_ABORT_FRM_STAT_BIT];
		auto_frame_repeat = enh & cfg_r[BCMCR_AUTO_REPEAT_BIT];
		internal_trigger_enable = enh & cfg_r[BCMCR_INT_TRIG_BIT];
		ext_en = enh & cfg_r[BCMCR_FRAME_TRIGGER_INPUT_BIT];
		fail_err = msg.done &
			failed(msg.err, retry_enable & msg.retry_ok);
		fail_stat = msg.done &
			failed(msg.stat_unexp, retry_enable & msg.retry_ok);
		msg_stop = (fail_err & abort_me) | (fail_stat & en_msg_stat);
		start_req = host_frame_start | (ext_en & trig_rise);
	end

	always_comb
	begin
		state_nxt = state_r;
		frame_start_nxt = 1'b0;
		bc_halt_nxt = 1'b0;
		frame_abort_nxt = frame_abort_r |
			(state_r == BCMCR_RUN &&
			((fail_err & en_frame_err) | (fail_stat & en_frame_stat)));
		unique case (state_r)
			BCMCR_IDLE:
			begin
				if (bc_mode && start_req)
				begin
					state_nxt = BCMCR_RUN;
					frame_start_nxt = 1'b1;
					frame_abort_nxt = 1'b0;
				end
			end
			BCMCR_RUN:
			begin
				if (!bc_mode || msg_stop)
				begin
					state_nxt = BCMCR_IDLE;
					bc_halt_nxt = 1'b1;
				end
				else if (frame_done)
				begin
					if (frame_abort_nxt)
					begin
						// A frame abort overrides auto repeat.
						state_nxt = BCMCR_IDLE;
						bc_halt_nxt = 1'b1;
					end
					else if (auto_frame_repeat && internal_trigger_enable && !timer_expired)
					begin
						state_nxt = BCMCR_WAIT;
					end
					else if (auto_frame_repeat)
					begin
						frame_start_nxt = 1'b1;
						frame_abort_nxt = 1'b0;
					end
					else
					begin
						state_nxt = BCMCR_IDLE;
					end
				end
			end
			BCMCR_WAIT:
			begin
				if (!auto_frame_repeat)
				begin
					state_nxt = BCMCR_IDLE;
				end
				else if (timer_expired)
				begin
					state_nxt = BCMCR_RUN;
					frame_start_nxt = 1'b1;
					frame_abort_nxt = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r <= BCMCR_IDLE;
			frame_abort_r <= 1'b0;
			frame_start_r <= 1'b0;
			bc_halt_r <= 1'b0;
			bc_active_r <= 1'b0;
			bc_mode_r <= 1'b0;
			enhanced_r <= 1'b0;
			memory_area_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			frame_abort_r <= frame_abort_nxt;
			frame_start_r <= frame_start_nxt;
			bc_halt_r <= bc_halt_nxt;
			bc_active_r <= (state_nxt != BCMCR_IDLE);
			bc_mode_r <= bc_mode;
			enhanced_r <= enh;
			memory_area_r <= cfg_r[BCMCR_MEM_AREA_BIT];
		end
	end

	chk_write_readback: assert property (@(posedge ref_clk) disable iff (!rst_b)
		host_wr && cfg1_hit(host_addr) ##1 host_rd && cfg1_hit(host_addr)
		&& !host_wr |=> host_rdata_r == $past(host_wdata, 2))
		else $error("register readback differs from write");
	chk_bc_select: assert property (@(posedge ref_clk) disable iff (!rst_b)
		host_wr && cfg1_hit(host_addr) && !host_wdata[15] ##1 !host_wr
		|=> bc_mode_r)
		else $error("bc mode not entered after clearing bit 15");
	chk_mem_area: assert property (@(posedge ref_clk) disable iff (!rst_b)
		host_wr && cfg1_hit(host_addr) ##1 !host_wr
		|=> memory_area_r == $past(host_wdata[13], 2))
		else $error("memory area select wrong");
	chk_msg_abort: assert property (@(posedge ref_clk) disable iff (!rst_b)
		state_r == BCMCR_RUN && bc_mode && fail_err && abort_me
		|=> bc_halt_r && !bc_active_r)
		else $error("no halt after message error");
	chk_retry_saves: assert property (@(posedge ref_clk) disable iff (!rst_b)
		state_r == BCMCR_RUN && bc_mode && msg.done && retry_enable
		&& msg.retry_ok && !frame_done |=> !bc_halt_r)
		else $error("halt despite successful retry");
	chk_legacy_inert: assert property (@(posedge ref_clk) disable iff (!rst_b)
		state_r == BCMCR_RUN && !enh && frame_done && !msg_stop
		|=> !frame_start_r && !bc_active_r)
		else $error("legacy mode repeated a frame");
	chk_enh_decode: assert property (@(posedge ref_clk) disable iff (!rst_b)
		enhanced_r == (!$past(cfg_r[BCMCR_OP_MODE_BIT])
		&& $past(cfg3_enhanced)))
		else $error("enhanced mode decode wrong");
	chk_frame_abort: assert property (@(posedge ref_clk) disable iff (!rst_b)
		state_r == BCMCR_RUN && bc_mode && frame_done && frame_abort_nxt
		&& !msg_stop |=> bc_halt_r && !frame_start_r)
		else $error("frame abort did not stop the controller");
	chk_stat_msg: assert property (@(posedge ref_clk) disable iff (!rst_b)
		state_r == BCMCR_RUN && fail_stat && en_msg_stat
		|=> bc_halt_r)
		else $error("no halt after unexpected status");
	chk_auto_repeat: assert property (@(posedge ref_clk) disable iff (!rst_b)
		state_r == BCMCR_RUN && bc_mode && frame_done && auto_frame_repeat && !internal_trigger_enable
		&& !frame_abort_nxt && !msg_stop |=> frame_start_r ##1 !frame_start_r)
		else $error("auto repeat did not restart the frame");
	chk_frame_trigger_input: assert property (@(posedge ref_clk) disable iff (!rst_b)
		state_r == BCMCR_IDLE && bc_mode && ext_en && trig_rise
		|=> frame_start_r && bc_active_r)
		else $error("trigger edge did not start a frame");
	chk_period_start: assert property (@(posedge ref_clk) disable iff (!rst_b)
		state_r == BCMCR_WAIT && auto_frame_repeat && timer_expired |=> frame_start_r)
		else $error("fixed period expiry did not start a frame");

	cov_auto_frames: cover property (@(posedge ref_clk) disable iff (!rst_b)
		frame_start_r ##[1:300] frame_start_r);
	cov_period_wait: cover property (@(posedge ref_clk) disable iff (!rst_b)
		state_r == BCMCR_WAIT ##1 frame_start_r);
	cov_frame_halt: cover property (@(posedge ref_clk) disable iff (!rst_b)
		frame_abort_r && frame_done ##1 bc_halt_r);

endmodule

// >>> bcmcr_pkg.sv
package bcmcr_pkg;

	localparam logic [4:0] BCMCR_CFG1_ADDR = 5'h01;
	localparam logic [15:0] BCMCR_CFG1_RESET = 16'h8000;

	localparam int BCMCR_OP_MODE_BIT = 15;
	localparam int BCMCR_SEC_MODE_BIT = 14;
	localparam int BCMCR_MEM_AREA_BIT = 13;
	localparam int BCMCR_ABORT_MSG_ERR_BIT = 12;
	localparam int BCMCR_ABORT_FRM_ERR_BIT = 11;
	localparam int BCMCR_ABORT_MSG_STAT_BIT = 10;
	localparam int BCMCR_ABORT_FRM_STAT_BIT = 9;
	localparam int BCMCR_AUTO_REPEAT_BIT = 8;
	localparam int BCMCR_FRAME_TRIGGER_INPUT_BIT = 7;
	localparam int BCMCR_INT_TRIG_BIT = 6;

	localparam int BCMCR_CLK_HZ = 40000000;
	localparam int BCMCR_FRAME_UNIT_NS = 100000;
	localparam int BCMCR_UNIT_CYCLES =
		BCMCR_FRAME_UNIT_NS / 1000 * (BCMCR_CLK_HZ / 1000000);

	typedef struct packed {
		logic done;
		logic err;
		logic stat_unexp;
		logic retry_ok;
	} bcmcr_msg_t;

	typedef enum logic [2:0] {
		BCMCR_IDLE = 3'h1,
		BCMCR_RUN = 3'h2,
		BCMCR_WAIT = 3'h4
	} bcmcr_state_t;

endpackage

// >>> bcmcr_trig_sync.sv
`timescale 1ns/1ps
module bcmcr_trig_sync
	import bcmcr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic pin_in,
	output logic rise_r
);

	logic meta_r;
	logic sync_r;
	logic prev_r;
	logic rise_nxt;

	always_comb
	begin
		rise_nxt = sync_r & ~prev_r;
	end

	// The edge detector looks only at the second stage of the synchroniser.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
			rise_r <= 1'b0;
		end
		else
		begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
			rise_r <= rise_nxt;
		end
	end

endmodule

// >>> bcmcr_frame_timer.sv
`timescale 1ns/1ps
module bcmcr_frame_timer
	import bcmcr_pkg::*;
#(
	parameter int UNIT_CYCLES = BCMCR_UNIT_CYCLES
)
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [15:0] units,
	output logic expired_r
);

	logic [11:0] pre_r;
	logic [11:0] pre_nxt;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic run_r;
	logic run_nxt;
	logic expired_nxt;

	always_comb
	begin
		pre_nxt = pre_r;
		cnt_nxt = cnt_r;
		run_nxt = run_r;
		expired_nxt = expired_r;
		if (start)
		begin
			pre_nxt = 12'h000;
			cnt_nxt = 16'h0000;
			run_nxt = (units != 16'h0000);
			expired_nxt = (units == 16'h0000);
		end
		else if (run_r)
		begin
			if (pre_r == 12'(UNIT_CYCLES - 1))
			begin
				pre_nxt = 12'h000;
				cnt_nxt = cnt_r + 16'h0001;
				if (cnt_nxt >= units)
				begin
					run_nxt = 1'b0;
					expired_nxt = 1'b1;
				end
			end
			else
			begin
				pre_nxt = pre_r + 12'h001;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pre_r <= 12'h000;
			cnt_r <= 16'h0000;
			run_r <= 1'b0;
			expired_r <= 1'b0;
		end
		else
		begin
			pre_r <= pre_nxt;
			cnt_r <= cnt_nxt;
			run_r <= run_nxt;
			expired_r <= expired_nxt;
		end
	end

endmodule

// >>> bcmcr_mode_cfg_tb_top.sv
`timescale 1ns/1ps
module bcmcr_mode_cfg_tb_top
	import bcmcr_pkg::*;
;
	logic ref_clk;
	logic rst_b;
	logic [4:0] host_addr;
	logic [15:0] host_wdata;
	logic host_wr;
	logic host_rd;
	logic [15:0] host_rdata_r;
	logic host_frame_start;
	logic cfg3_enhanced;
	logic [15:0] frame_time;
	logic retry_enable;
	bcmcr_msg_t msg;
	logic frame_done;
	logic frame_trigger_input;
	logic frame_start_r;
	logic bc_halt_r;
	logic bc_active_r;
	logic bc_mode_r;
	logic enhanced_r;
	logic memory_area_r;
	int n_mismatch;
	int compares;
	logic [31:0] seed;
	logic [31:0] d;

	// A short timer unit keeps the fixed-period frames a few cycles long.
	bcmcr_mode_cfg #(.UNIT_CYCLES(4)) dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
		.host_rdata_r(host_rdata_r), .host_frame_start(host_frame_start),
		.cfg3_enhanced(cfg3_enhanced), .frame_time(frame_time),
		.retry_enable(retry_enable), .msg(msg), .frame_done(frame_done),
		.frame_trigger_input(frame_trigger_input),
		.frame_start_r(frame_start_r), .bc_halt_r(bc_halt_r),
		.bc_active_r(bc_active_r), .bc_mode_r(bc_mode_r),
		.enhanced_r(enhanced_r), .memory_area_r(memory_area_r)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		compares++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	task automatic chk_flag(input string nm, input logic e, input logic g);
		compares++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %b, seen %b", nm, e, g);
		end
	endtask

	// Pulses stand one cycle, so every negedge in the span is looked at.
	// The span opens at the calling negedge, where a pulse launched by the
	// strobe that was just released already stands.
	task automatic expect_pulse(input string nm, input logic halt,
		input int n, input logic e);
		logic seen;
		seen = ((halt ? bc_halt_r : frame_start_r) === 1'b1);
		repeat (n - 1)
		begin
			@(negedge ref_clk);
			if ((halt ? bc_halt_r : frame_start_r) === 1'b1)
				seen = 1'b1;
		end
		chk_flag(nm, e, seen);
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(negedge ref_clk);
		host_addr = a;
		host_wdata = v;
		host_wr = 1'b1;
		@(negedge ref_clk);
		host_wr = 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(negedge ref_clk);
		host_addr = a;
		host_rd = 1'b1;
		@(negedge ref_clk);
		host_rd = 1'b0;
		@(negedge ref_clk);
		chk("read data", e, host_rdata_r);
	endtask

	task automatic start_frame();
		@(negedge ref_clk);
		host_frame_start = 1'b1;
		@(negedge ref_clk);
		host_frame_start = 1'b0;
		expect_pulse("frame start", 1'b0, 3, 1'b1);
	endtask

	task automatic end_frame();
		@(negedge ref_clk);
		frame_done = 1'b1;
		@(negedge ref_clk);
		frame_done = 1'b0;
	endtask

	task automatic msg_end(input logic e, input logic s, input logic r);
		@(negedge ref_clk);
		msg = '{done: 1'b1, err: e, stat_unexp: s, retry_ok: r};
		@(negedge ref_clk);
		msg = '0;
	endtask

	task automatic results();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		#(25 * 20000);
		n_mismatch++;
		results();
	end

	initial
	begin
		n_mismatch = 0;
		compares = 0;
		seed = 32'h6667;
		rst_b = 1'b0;
		host_addr = 5'h00;
		host_wdata = 16'h0000;
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_frame_start = 1'b0;
		cfg3_enhanced = 1'b0;
		frame_time = 16'h0002;
		retry_enable = 1'b0;
		msg = '0;
		frame_done = 1'b0;
		frame_trigger_input = 1'b0;
		repeat (2) @(negedge ref_clk);
		rst_b = 1'b1;
		rd(BCMCR_CFG1_ADDR, 16'h8000);
		chk_flag("bc mode", 1'b0, bc_mode_r);
		wr(5'h02, 16'h1234);
		rd(5'h02, 16'h0000);
		rd(BCMCR_CFG1_ADDR, 16'h8000);
		repeat (8)
		begin
			d = rnd();
			cfg3_enhanced = d[16];
			wr(BCMCR_CFG1_ADDR, d[15:0]);
			rd(BCMCR_CFG1_ADDR, d[15:0]);
			chk_flag("bc mode", ~d[15], bc_mode_r);
			chk_flag("memory area", d[13], memory_area_r);
			chk_flag("enhanced", ~d[15] & d[16], enhanced_r);
		end
		// A read right behind a write must return the word just written.
		@(negedge ref_clk);
		host_addr = BCMCR_CFG1_ADDR;
		host_wdata = 16'h2000;
		host_wr = 1'b1;
		@(negedge ref_clk);
		host_wr = 1'b0;
		host_rd = 1'b1;
		@(negedge ref_clk);
		host_rd = 1'b0;
		chk("read data", 16'h2000, host_rdata_r);
		chk_flag("memory area", 1'b1, memory_area_r);
		cfg3_enhanced = 1'b0;
		wr(BCMCR_CFG1_ADDR, 16'h1500);
		start_frame();
		msg_end(1'b0, 1'b1, 1'b0);
		expect_pulse("halt", 1'b1, 3, 1'b0);
		retry_enable = 1'b1;
		msg_end(1'b1, 1'b0, 1'b1);
		expect_pulse("halt", 1'b1, 3, 1'b0);
		msg_end(1'b1, 1'b0, 1'b0);
		expect_pulse("halt", 1'b1, 2, 1'b1);
		chk_flag("active", 1'b0, bc_active_r);
		retry_enable = 1'b0;
		wr(BCMCR_CFG1_ADDR, 16'h0100);
		start_frame();
		end_frame();
		expect_pulse("frame start", 1'b0, 4, 1'b0);
		chk_flag("active", 1'b0, bc_active_r);
		cfg3_enhanced = 1'b1;
		wr(BCMCR_CFG1_ADDR, 16'h0300);
		start_frame();
		end_frame();
		expect_pulse("frame start", 1'b0, 3, 1'b1);
		msg_end(1'b0, 1'b1, 1'b0);
		expect_pulse("halt", 1'b1, 3, 1'b0);
		end_frame();
		expect_pulse("halt", 1'b1, 2, 1'b1);
		wr(BCMCR_CFG1_ADDR, 16'h0800);
		start_frame();
		msg_end(1'b1, 1'b0, 1'b0);
		expect_pulse("halt", 1'b1, 3, 1'b0);
		end_frame();
		expect_pulse("halt", 1'b1, 2, 1'b1);
		wr(BCMCR_CFG1_ADDR, 16'h0400);
		start_frame();
		msg_end(1'b0, 1'b1, 1'b0);
		expect_pulse("halt", 1'b1, 2, 1'b1);
		wr(BCMCR_CFG1_ADDR, 16'h0000);
		start_frame();
		end_frame();
		expect_pulse("frame start", 1'b0, 4, 1'b0);
		chk_flag("active", 1'b0, bc_active_r);
		@(negedge ref_clk);
		frame_trigger_input = 1'b1;
		expect_pulse("frame start", 1'b0, 6, 1'b0);
		frame_trigger_input = 1'b0;
		wr(BCMCR_CFG1_ADDR, 16'h0080);
		@(negedge ref_clk);
		frame_trigger_input = 1'b1;
		expect_pulse("frame start", 1'b0, 6, 1'b1);
		end_frame();
		frame_trigger_input = 1'b0;
		// Two units of four cycles plus two cycles, ten in all, from frame start to the next one.
		wr(BCMCR_CFG1_ADDR, 16'h0140);
		start_frame();
		end_frame();
		expect_pulse("frame start", 1'b0, 4, 1'b0);
		expect_pulse("frame start", 1'b0, 8, 1'b1);
		wr(BCMCR_CFG1_ADDR, 16'h0000);
		end_frame();
		expect_pulse("frame start", 1'b0, 12, 1'b0);
		results();
	end
endmodule
